// ==== src/scgen_pkg.sv ====
// constants and types for the system and audio clock generator
package scgen_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CLKEN0  = 8'h63;
  localparam logic [7:0] ADDR_CLKEN1  = 8'h64;
  localparam logic [7:0] ADDR_MODULE_CLOCK_ENABLE_2  = 8'h65;
  localparam logic [7:0] ADDR_SYSTEM_CLOCK_SELECT  = 8'h66;
  localparam logic [7:0] ADDR_I2SSTEP = 8'h67;
  localparam logic [7:0] ADDR_I2SMOD  = 8'h68;
  localparam logic [7:0] ADDR_CDCSTEP = 8'h6c;
  localparam logic [7:0] ADDR_CDCMOD  = 8'h6d;
  localparam logic [7:0] ADDR_HSUPPER = 8'h70;
  localparam logic [7:0] ADDR_STATUS  = 8'h74;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_CLKEN0  = 8'h83;
  localparam logic [7:0] RST_CLKEN1  = 8'h00;
  localparam logic [7:0] RST_MODULE_CLOCK_ENABLE_2  = 8'h30;
  localparam logic [7:0] RST_SYSTEM_CLOCK_SELECT  = 8'h06;
  localparam logic [7:0] RST_I2SSTEP = 8'h00;
  localparam logic [7:0] RST_I2SMOD  = 8'h02;
  localparam logic [7:0] RST_CDCSTEP = 8'h01;
  localparam logic [7:0] RST_CDCMOD  = 8'h02;
  localparam logic [7:0] RST_HSUPPER = 8'h00;

  // ----------------------------------------------------------------
  // field positions and module count
  // ----------------------------------------------------------------
  localparam int SRC_MSB     = 6;
  localparam int SRC_LSB     = 5;
  localparam int DIV_MSB     = 4;
  localparam int HS_LOW_BIT  = 7;
  localparam int HS_HIGH_BIT = 0;
  localparam int FEN_BIT     = 7;
  localparam int STEP_MSB    = 6;
  localparam int MODULE_NUM  = 24;

  // fixed two-thirds ratio
  localparam logic [6:0] TWO_THIRDS_STEP = 7'h02;
  localparam logic [7:0] TWO_THIRDS_MOD  = 8'h03;

  typedef enum logic [1:0] {
    SRC_RC    = 2'b00,
    SRC_HS    = 2'b01,
    SRC_HSDIV = 2'b10,
    SRC_32M   = 2'b11
  } scgen_src_t;

  typedef enum logic [1:0] {
    HS_DBL   = 2'b00,
    HS_RC    = 2'b01,
    HS_PAD0  = 2'b10,
    HS_PAD1  = 2'b11
  } scgen_hs_t;

  typedef struct packed {
    logic       en;
    logic [6:0] step;
    logic [7:0] modulus;
  } scgen_frac_cfg_t;

endpackage : scgen_pkg

// ==== src/scgen_frac_div.sv ====
// step/modulus accumulator divider on a tick stream
`timescale 1ns/1ns
`default_nettype none
module scgen_frac_div
  import scgen_pkg::*;
(
  input  wire logic            clk_in,
  input  wire logic            rst_in,
  input  wire logic            tick_in,
  input  wire scgen_frac_cfg_t cfg_in,
  output logic                 pulse_out
);

  logic [8:0] sum;
  logic [7:0] acc_ff;
  logic       wrap;

  // ----------------------------------------------------------------
  // accumulator
  // ----------------------------------------------------------------
  // one wrap per tick at most, since modulus stays at or above the step
  always_comb
  begin
    sum  = {1'b0, acc_ff} + {2'b00, cfg_in.step};
    wrap = tick_in && cfg_in.en && (cfg_in.modulus != 8'h00) &&
           (sum >= {1'b0, cfg_in.modulus});
  end

  // RL19: add step, wrap at modulus
  always_ff @(posedge clk_in)
  begin
    if (rst_in || !cfg_in.en)
      acc_ff <= 8'h00;
    else if (wrap)
      acc_ff <= 8'(sum - {1'b0, cfg_in.modulus});
    else if (tick_in)
      acc_ff <= sum[7:0];
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      pulse_out <= 1'b0;
    else
      pulse_out <= wrap;
  end

  frac_pulse_src_a: assert property ( // RL19
    @(posedge clk_in) disable iff (rst_in)
    pulse_out |-> $past(tick_in) && $past(cfg_in.en))
    else $error("divider pulsed without tick or enable");

  frac_off_a: assert property ( // RL12
    @(posedge clk_in) disable iff (rst_in)
    !cfg_in.en |=> !pulse_out)
    else $error("disabled divider produced a pulse");

endmodule : scgen_frac_div
`default_nettype wire

// ==== src/scgen_top.sv ====
// system, timer, audio clock generation and module clock gating
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
// Contract
// RL1: core clock chosen from four sources by a two-bit field.
// RL2: field 00 rc, 01 high speed, 10 divided high speed, 11 32 MHz.
// RL3: 32 MHz candidate is 48 MHz times two thirds.
// RL4: high-speed clock chosen by a select split over two registers.
// RL5: 00 doubled 48 MHz, 01 rc, 1x crystal pad clock.
// RL6: in divided mode output equals high speed over five-bit divider.
// RL7: software never writes divider values zero or one.
// RL8: 48 MHz made by doubling crystal; it feeds audio dividers.
// RL9: three enable registers gate clocks of individual modules.
// RL10: enable bit one passes the module clock, zero stops it.
// RL11: timer clock fixed 16 MHz, crystal through two-thirds divider.
// RL12: serial-audio clock runs only while its enable bit is set.
// RL13: serial-audio step is seven low bits, modulus the next register.
// RL14: serial-audio rate is 48 MHz times step over modulus.
// RL15: software keeps every modulus at least twice its step.
// RL16: codec clock runs only while its enable bit is set.
// RL17: codec_divider_step is seven low bits, modulus the following register.
// RL18: codec rate is 48 MHz times step over modulus.
// RL19: fractional dividers accumulate step modulo modulus, pulse on wrap.
// RL20: selection and enable changes never cut a clock pulse short.
module scgen_top
  import scgen_pkg::*;
(
  input  wire logic                  ref_clk_in,
  input  wire logic                  rst_in,
  input  wire logic [7:0]            reg_addr_in,
  input  wire logic [7:0]            reg_wdata_in,
  input  wire logic                  reg_wr_in,
  input  wire logic                  reg_rd_in,
  output logic [7:0]                 reg_rdata_out,
  input  wire logic                  rc_oscillator_clock_in,
  input  wire logic                  crystal_pad_clock_in,
  output logic                       system_clock_out,
  output logic                       high_speed_clock_out,
  output logic                       timer_clock_out,
  output logic                       audio_serial_clock_out,
  output logic                       codec_clock_out,
  output logic [scgen_pkg::MODULE_NUM-1:0] module_clock_out
);
  import scgen_pkg::*;

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic [7:0] clken0_ff;
  logic [7:0] clken1_ff;
  logic [7:0] module_clock_enable_2_ff;
  logic [7:0] system_clock_select_ff;
  logic [7:0] i2s_step_ff;
  logic [7:0] i2s_mod_ff;
  logic [7:0] cdc_step_ff;
  logic [7:0] cdc_mod_ff;
  logic [7:0] hs_upper_ff;

  // ----------------------------------------------------------------
  // clock tick streams
  // ----------------------------------------------------------------
  // every clock here is a one-cycle enable on ref_clk_in
  logic            dbl_pend_ff;
  logic            dbl_tick;
  logic            hs_tick;
  logic            hsdiv_tick;
  logic            f32_tick;
  logic            tmr_tick;
  logic            i2s_tick;
  logic            cdc_tick;
  logic            sys_tick;
  logic [4:0]      hsdiv_cnt_ff;
  scgen_hs_t       hs_req;
  scgen_hs_t       hs_sel_ff;
  scgen_src_t      sys_req;
  scgen_src_t      sys_sel_ff;
  scgen_frac_cfg_t i2s_cfg;
  scgen_frac_cfg_t cdc_cfg;
  scgen_frac_cfg_t twothirds_cfg;
  logic [MODULE_NUM-1:0] mod_en;
  logic [7:0]      status;

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  // RL9: module enable registers
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      clken0_ff <= RST_CLKEN0;
      clken1_ff <= RST_CLKEN1;
      module_clock_enable_2_ff <= RST_MODULE_CLOCK_ENABLE_2;
    end
    else if (reg_wr_in)
    begin
      if (reg_addr_in == ADDR_CLKEN0)
        clken0_ff <= reg_wdata_in;
      else if (reg_addr_in == ADDR_CLKEN1)
        clken1_ff <= reg_wdata_in;
      else if (reg_addr_in == ADDR_MODULE_CLOCK_ENABLE_2)
        module_clock_enable_2_ff <= reg_wdata_in;
    end
  end

  // RL1: source and divider settings
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      system_clock_select_ff   <= RST_SYSTEM_CLOCK_SELECT;
      hs_upper_ff <= RST_HSUPPER;
    end
    else if (reg_wr_in)
    begin
      if (reg_addr_in == ADDR_SYSTEM_CLOCK_SELECT)
        system_clock_select_ff <= reg_wdata_in;
      else if (reg_addr_in == ADDR_HSUPPER)
        hs_upper_ff <= reg_wdata_in;
    end
  end

  // RL13: audio divider settings
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      i2s_step_ff <= RST_I2SSTEP;
      i2s_mod_ff  <= RST_I2SMOD;
      cdc_step_ff <= RST_CDCSTEP;
      cdc_mod_ff  <= RST_CDCMOD;
    end
    else if (reg_wr_in)
    begin
      if (reg_addr_in == ADDR_I2SSTEP)
        i2s_step_ff <= reg_wdata_in;
      else if (reg_addr_in == ADDR_I2SMOD)
        i2s_mod_ff <= reg_wdata_in;
      else if (reg_addr_in == ADDR_CDCSTEP)
        cdc_step_ff <= reg_wdata_in;
      else if (reg_addr_in == ADDR_CDCMOD)
        cdc_mod_ff <= reg_wdata_in;
    end
  end

  // ----------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------
  always_comb
  begin
    status = {2'b00, codec_clock_out, audio_serial_clock_out,
              hs_sel_ff, sys_sel_ff};
  end

  // data stands one cycle only; unmapped offsets read zero
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in || !reg_rd_in)
      reg_rdata_out <= 8'h00;
    else if (reg_addr_in == ADDR_CLKEN0)
      reg_rdata_out <= clken0_ff;
    else if (reg_addr_in == ADDR_CLKEN1)
      reg_rdata_out <= clken1_ff;
    else if (reg_addr_in == ADDR_MODULE_CLOCK_ENABLE_2)
      reg_rdata_out <= module_clock_enable_2_ff;
    else if (reg_addr_in == ADDR_SYSTEM_CLOCK_SELECT)
      reg_rdata_out <= system_clock_select_ff;
    else if (reg_addr_in == ADDR_I2SSTEP)
      reg_rdata_out <= i2s_step_ff;
    else if (reg_addr_in == ADDR_I2SMOD)
      reg_rdata_out <= i2s_mod_ff;
    else if (reg_addr_in == ADDR_CDCSTEP)
      reg_rdata_out <= cdc_step_ff;
    else if (reg_addr_in == ADDR_CDCMOD)
      reg_rdata_out <= cdc_mod_ff;
    else if (reg_addr_in == ADDR_HSUPPER)
      reg_rdata_out <= hs_upper_ff;
    else if (reg_addr_in == ADDR_STATUS)
      reg_rdata_out <= status;
    else
      reg_rdata_out <= 8'h00;
  end

  // ----------------------------------------------------------------
  // frequency doubler
  // ----------------------------------------------------------------
  // RL8: each crystal tick yields two 48 MHz ticks, back to back;
  // needs crystal ticks at least two cycles apart
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
      dbl_pend_ff <= 1'b0;
    else
      dbl_pend_ff <= crystal_pad_clock_in;
  end

  assign dbl_tick = crystal_pad_clock_in | dbl_pend_ff;

  // ----------------------------------------------------------------
  // high-speed clock select
  // ----------------------------------------------------------------
  function automatic logic hs_pick(input scgen_hs_t sel,
                                   input logic dbl,
                                   input logic rc,
                                   input logic pad);
    case (sel)
      HS_DBL:  hs_pick = dbl;
      HS_RC:   hs_pick = rc;
      default: hs_pick = pad;
    endcase
  endfunction : hs_pick

  // RL4: select split over two registers
  assign hs_req = scgen_hs_t'({hs_upper_ff[HS_HIGH_BIT],
                               system_clock_select_ff[HS_LOW_BIT]});

  // RL20: switch only while old and new sources are both idle
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
      hs_sel_ff <= HS_DBL;
    else if (!hs_pick(hs_sel_ff, dbl_tick, rc_oscillator_clock_in,
                      crystal_pad_clock_in) &&
             !hs_pick(hs_req, dbl_tick, rc_oscillator_clock_in,
                      crystal_pad_clock_in))
      hs_sel_ff <= hs_req;
  end

  // RL5: 00 doubled, 01 rc, 1x pad
  assign hs_tick = hs_pick(hs_sel_ff, dbl_tick, rc_oscillator_clock_in,
                           crystal_pad_clock_in);

  // ----------------------------------------------------------------
  // integer divider of the high-speed clock
  // ----------------------------------------------------------------
  // RL6: one pulse per divider-value high-speed ticks
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
      hsdiv_cnt_ff <= 5'h00;
    else if (hsdiv_tick)
      hsdiv_cnt_ff <= 5'h00;
    else if (hs_tick)
      hsdiv_cnt_ff <= hsdiv_cnt_ff + 5'h01;
  end

  // RL7: values zero and one are left undefined for software
  // compare with >= so a divider cut below the count still ends the period
  assign hsdiv_tick = hs_tick &&
                      (hsdiv_cnt_ff >= system_clock_select_ff[DIV_MSB:0] - 5'h01);

  // ----------------------------------------------------------------
  // fractional dividers
  // ----------------------------------------------------------------
  assign twothirds_cfg = '{en: 1'b1, step: TWO_THIRDS_STEP,
                           modulus: TWO_THIRDS_MOD};

  // RL3: 32 MHz from 48 MHz
  scgen_frac_div u_f32 (
    .clk_in    (ref_clk_in),
    .rst_in    (rst_in),
    .tick_in   (dbl_tick),
    .cfg_in    (twothirds_cfg),
    .pulse_out (f32_tick)
  );

  // RL11: 16 MHz timer clock from crystal
  scgen_frac_div u_tmr (
    .clk_in    (ref_clk_in),
    .rst_in    (rst_in),
    .tick_in   (crystal_pad_clock_in),
    .cfg_in    (twothirds_cfg),
    .pulse_out (tmr_tick)
  );

  // RL12: enable bit; RL13: step and modulus fields
  assign i2s_cfg = '{en: i2s_step_ff[FEN_BIT],
                     step: i2s_step_ff[STEP_MSB:0],
                     modulus: i2s_mod_ff};

  // RL14: 48 MHz times step over modulus
  scgen_frac_div u_i2s (
    .clk_in    (ref_clk_in),
    .rst_in    (rst_in),
    .tick_in   (dbl_tick),
    .cfg_in    (i2s_cfg),
    .pulse_out (i2s_tick)
  );

  // RL16: enable bit; RL17: step and modulus fields
  assign cdc_cfg = '{en: cdc_step_ff[FEN_BIT],
                     step: cdc_step_ff[STEP_MSB:0],
                     modulus: cdc_mod_ff};

  // RL18: 48 MHz times step over modulus
  scgen_frac_div u_cdc (
    .clk_in    (ref_clk_in),
    .rst_in    (rst_in),
    .tick_in   (dbl_tick),
    .cfg_in    (cdc_cfg),
    .pulse_out (cdc_tick)
  );

  // ----------------------------------------------------------------
  // system clock select
  // ----------------------------------------------------------------
  function automatic logic sys_pick(input scgen_src_t sel,
                                    input logic rc,
                                    input logic hs,
                                    input logic hsd,
                                    input logic f32);
    case (sel)
      SRC_RC:    sys_pick = rc;
      SRC_HS:    sys_pick = hs;
      SRC_HSDIV: sys_pick = hsd;
      default:   sys_pick = f32;
    endcase
  endfunction : sys_pick

  assign sys_req = scgen_src_t'(system_clock_select_ff[SRC_MSB:SRC_LSB]);

  // RL20: hand over between pulses, never inside one
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
      sys_sel_ff <= SRC_RC;
    else if (!sys_pick(sys_sel_ff, rc_oscillator_clock_in, hs_tick,
                       hsdiv_tick, f32_tick) &&
             !sys_pick(sys_req, rc_oscillator_clock_in, hs_tick,
                       hsdiv_tick, f32_tick))
      sys_sel_ff <= sys_req;
  end

  // RL1: chosen source; RL2: encoding
  assign sys_tick = sys_pick(sys_sel_ff, rc_oscillator_clock_in,
                             hs_tick, hsdiv_tick, f32_tick);

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      system_clock_out       <= 1'b0;
      high_speed_clock_out   <= 1'b0;
      timer_clock_out        <= 1'b0;
      audio_serial_clock_out <= 1'b0;
      codec_clock_out        <= 1'b0;
    end
    else
    begin
      system_clock_out       <= sys_tick;
      high_speed_clock_out   <= hs_tick;
      timer_clock_out        <= tmr_tick;
      audio_serial_clock_out <= i2s_tick;
      codec_clock_out        <= cdc_tick;
    end
  end

  // ----------------------------------------------------------------
  // module clock gating
  // ----------------------------------------------------------------
  assign mod_en = {module_clock_enable_2_ff, clken1_ff, clken0_ff};

  // RL10: one passes, zero stops; enables move only between pulses
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
      module_clock_out <= '0;
    else
      module_clock_out <= {MODULE_NUM{sys_tick}} & mod_en;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  system_clock_select_write_a: assert property ( // RL1
    @(posedge ref_clk_in) disable iff (rst_in)
    reg_wr_in && reg_addr_in == ADDR_SYSTEM_CLOCK_SELECT
    |=> system_clock_select_ff == $past(reg_wdata_in))
    else $error("select register missed a write");

  read_window_a: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    !reg_rd_in |=> reg_rdata_out == 8'h00)
    else $error("read data outside its cycle");

  sys_source_a: assert property ( // RL2
    @(posedge ref_clk_in) disable iff (rst_in)
    sys_sel_ff == SRC_RC && rc_oscillator_clock_in
    |=> system_clock_out)
    else $error("rc source not passed to system clock");

  hs_pad_a: assert property ( // RL5
    @(posedge ref_clk_in) disable iff (rst_in)
    hs_sel_ff[1] |-> hs_tick == crystal_pad_clock_in)
    else $error("pad select not followed");

  hsdiv_count_a: assert property ( // RL6
    @(posedge ref_clk_in) disable iff (rst_in)
    hsdiv_tick |=> hsdiv_cnt_ff == 5'h00)
    else $error("divider count not restarted");

  doubler_pair_a: assert property ( // RL8
    @(posedge ref_clk_in) disable iff (rst_in)
    crystal_pad_clock_in |-> dbl_tick ##1 dbl_tick)
    else $error("doubler missed second tick");

  sel_switch_a: assert property ( // RL20
    @(posedge ref_clk_in) disable iff (rst_in)
    $changed(sys_sel_ff) |-> !$past(sys_tick))
    else $error("source switched inside a pulse");

  gate_pass_a: assert property ( // RL10
    @(posedge ref_clk_in) disable iff (rst_in)
    sys_tick && mod_en[0] |=> module_clock_out[0])
    else $error("enabled module clock not passed");

endmodule : scgen_top
`default_nettype wire

// ==== dv/scgen_tb.sv ====
// self-checking bench for the system and audio clock generator
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import scgen_pkg::*;

  typedef struct {
    logic [1:0] hs;
    logic [1:0] src;
    logic [4:0] dv;
    bit         pad;
    int         n;
    int         es;
    int         eh;
  } scgen_case_t;

  logic                  ref_clk_in;
  logic                  rst_in;
  logic                  reg_wr_in;
  logic                  reg_rd_in;
  logic                  rc_tick;
  logic                  pad_tick;
  logic [7:0]            reg_addr_in;
  logic [7:0]            reg_wdata_in;
  logic [7:0]            reg_rdata_out;
  logic                  sys_out;
  logic                  hs_out;
  logic                  tmr_out;
  logic                  aud_out;
  logic                  cdc_out;
  logic [MODULE_NUM-1:0] mod_out;
  logic [MODULE_NUM-1:0] exp_gate;
  logic [7:0]            exp_q[$];
  logic                  rd_seen;
  logic [7:0]            addrs[9];
  logic [7:0]            rsts[9];
  logic [7:0]            d;
  int failures;
  int checks;
  int n_sys;
  int n_hs;
  int n_tmr;
  int n_aud;
  int n_cdc;
  int c_sys;
  int c_hs;
  int c_tmr;
  int c_aud;
  int c_cdc;
  int seed;
  scgen_case_t tab[7];

  scgen_top u_scgen_top (
    .ref_clk_in             (ref_clk_in),
    .rst_in                 (rst_in),
    .reg_addr_in            (reg_addr_in),
    .reg_wdata_in           (reg_wdata_in),
    .reg_wr_in              (reg_wr_in),
    .reg_rd_in              (reg_rd_in),
    .reg_rdata_out          (reg_rdata_out),
    .rc_oscillator_clock_in (rc_tick),
    .crystal_pad_clock_in   (pad_tick),
    .system_clock_out       (sys_out),
    .high_speed_clock_out   (hs_out),
    .timer_clock_out        (tmr_out),
    .audio_serial_clock_out (aud_out),
    .codec_clock_out        (cdc_out),
    .module_clock_out       (mod_out)
  );

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: %s seen %0h expected %0h",
               $time, what, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] dat);
    @(posedge ref_clk_in);
    reg_addr_in  <= a;
    reg_wdata_in <= dat;
    reg_wr_in    <= 1'b1;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
    if (a == ADDR_CLKEN0)
      exp_gate[7:0] = dat;
    if (a == ADDR_CLKEN1)
      exp_gate[15:8] = dat;
    if (a == ADDR_MODULE_CLOCK_ENABLE_2)
      exp_gate[23:16] = dat;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    exp_q.push_back(e);
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
  endtask : rd

  // crystal ticks kept at least two cycles apart, random extra gaps
  task automatic ticks(input bit pad, input int n);
    repeat (n)
    begin
      @(posedge ref_clk_in);
      if (pad)
        pad_tick <= 1'b1;
      else
        rc_tick <= 1'b1;
      @(posedge ref_clk_in);
      pad_tick <= 1'b0;
      rc_tick  <= 1'b0;
      repeat (int'(pad) + ($random(seed) & 1)) @(posedge ref_clk_in);
    end
    repeat (6) @(posedge ref_clk_in);
  endtask : ticks

  task automatic complete_run;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run

  // ------------------------------------------------------------
  // output watcher, sampled mid-cycle where outputs are settled
  // ------------------------------------------------------------
  always @(posedge ref_clk_in)
    rd_seen <= reg_rd_in;

  always @(negedge ref_clk_in)
  begin
    if (rst_in === 1'b0)
    begin
      if (rd_seen === 1'b1)
        check(reg_rdata_out, exp_q.pop_front(), "read data");
      else
        check(reg_rdata_out, 8'h00, "idle read data");
      check(mod_out, (sys_out === 1'b1) ? exp_gate : '0, "gates");
      n_sys += int'(sys_out === 1'b1);
      n_hs  += int'(hs_out === 1'b1);
      n_tmr += int'(tmr_out === 1'b1);
      n_aud += int'(aud_out === 1'b1);
      n_cdc += int'(cdc_out === 1'b1);
    end
  end

  initial
  begin
    ref_clk_in = 1'b0;
    forever #20 ref_clk_in = ~ref_clk_in;
  end

  // watchdog sized well above the expected run length
  initial
  begin
    #(40 * 40000);
    failures++;
    complete_run();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    seed = 32'h633d;
    rst_in = 1'b1;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    rc_tick = 1'b0;
    pad_tick = 1'b0;
    reg_addr_in = 8'h00;
    reg_wdata_in = 8'h00;
    rd_seen = 1'b0;
    exp_gate = {RST_MODULE_CLOCK_ENABLE_2, RST_CLKEN1, RST_CLKEN0};
    addrs = '{ADDR_CLKEN0, ADDR_CLKEN1, ADDR_MODULE_CLOCK_ENABLE_2, ADDR_SYSTEM_CLOCK_SELECT,
              ADDR_I2SSTEP, ADDR_I2SMOD, ADDR_CDCSTEP, ADDR_CDCMOD,
              ADDR_HSUPPER};
    rsts = '{RST_CLKEN0, RST_CLKEN1, RST_MODULE_CLOCK_ENABLE_2, RST_SYSTEM_CLOCK_SELECT, RST_I2SSTEP,
             RST_I2SMOD, RST_CDCSTEP, RST_CDCMOD, RST_HSUPPER};
    tab = '{'{2'b00, 2'b00, 5'h06, 1'b0, 20, 20, 0},
            '{2'b01, 2'b01, 5'h06, 1'b0, 20, 20, 20},
            '{2'b00, 2'b01, 5'h06, 1'b1, 10, 20, 20},
            '{2'b10, 2'b01, 5'h06, 1'b1, 10, 10, 10},
            '{2'b11, 2'b10, 5'h02, 1'b1, 10, 5, 10},
            '{2'b01, 2'b10, 5'h05, 1'b0, 50, 10, 50},
            '{2'b00, 2'b11, 5'h06, 1'b1, 30, 40, 60}};
    repeat (10) @(posedge ref_clk_in);
    rst_in <= 1'b0;

    foreach (addrs[i])
      rd(addrs[i], rsts[i]);
    rd(ADDR_STATUS, 8'h00);
    wr(8'h69, 8'hff);
    rd(8'h69, 8'h00);
    foreach (addrs[i])
    begin
      d = 8'($random(seed));
      if (addrs[i] == ADDR_SYSTEM_CLOCK_SELECT && d[4:1] == 4'h0)
        d[4:0] = 5'h02;
      // step at most one, modulus two or more
      if (addrs[i] == ADDR_I2SSTEP || addrs[i] == ADDR_CDCSTEP)
        d[6:1] = 6'h00;
      if (addrs[i] == ADDR_I2SMOD || addrs[i] == ADDR_CDCMOD)
        d[1] = 1'b1;
      wr(addrs[i], d);
      rd(addrs[i], d);
    end
    $display("test registers done");

    foreach (tab[i])
    begin
      for (int k = 0; k < 3; k++)
        wr(ADDR_CLKEN0 + 8'(k), 8'($random(seed)));
      wr(ADDR_HSUPPER, {7'h00, tab[i].hs[1]});
      wr(ADDR_SYSTEM_CLOCK_SELECT, {tab[i].hs[0], tab[i].src, tab[i].dv});
      repeat (4) @(posedge ref_clk_in);
      rd(ADDR_STATUS, {4'h0, tab[i].hs, tab[i].src});
      c_sys = n_sys;
      c_hs = n_hs;
      ticks(tab[i].pad, tab[i].n);
      check(n_sys - c_sys, tab[i].es, "system pulses");
      check(n_hs - c_hs, tab[i].eh, "high speed pulses");
    end
    $display("test source select done");

    // disable first: clears accumulators left by random settings
    wr(ADDR_I2SSTEP, 8'h00);
    wr(ADDR_CDCSTEP, 8'h00);
    // moduli before steps, twice the step or more
    wr(ADDR_I2SMOD, 8'h0c);
    wr(ADDR_CDCMOD, 8'h04);
    // 30 crystal ticks give 60 doubled ticks, a whole number of periods
    wr(ADDR_I2SSTEP, 8'h85);
    wr(ADDR_CDCSTEP, 8'h81);
    for (int r = 0; r < 2; r++)
    begin
      c_tmr = n_tmr;
      c_aud = n_aud;
      c_cdc = n_cdc;
      ticks(1'b1, 30);
      check(n_tmr - c_tmr, 20, "timer pulses");
      check(n_aud - c_aud, (r == 0) ? 25 : 0, "audio");
      check(n_cdc - c_cdc, (r == 0) ? 15 : 0, "codec");
      wr(ADDR_I2SSTEP, 8'h05);
      wr(ADDR_CDCSTEP, 8'h01);
    end
    $display("test audio dividers done");
    repeat (3) @(posedge ref_clk_in);
    complete_run();
  end
endmodule : testbench
`default_nettype wire
